// ===== dpsp_defines.svh
`ifndef DPSP_DEFINES_SVH
`define DPSP_DEFINES_SVH

// Array geometry
`define DPSP_ADDR_W      15
`define DPSP_DATA_W      18
`define DPSP_LANE_W      9
// Counter clear value
`define DPSP_ADDR_ZERO   15'h0000
// Write strobe width in cycles, self-timed after capture
`define DPSP_WSTB_CYC    1
// Outputs come back after this many selected samples
`define DPSP_REACT_CYC   2'h2
`define DPSP_REACT_W     2

`endif

// ===== dpsp_pkg.sv
`include "dpsp_defines.svh"

package dpsp_pkg;

    typedef enum logic [1:0] {
        DPSP_ACTIVE,
        DPSP_POWER_DOWN,
        DPSP_WAKE
    } dpsp_power_type;

    // Controls as sampled at a rising edge
    typedef struct packed {
        logic address_load_n;
        logic count_advance_n;
        logic counter_clear_n;
        logic chip_select_active_low;
        logic chip_select_active_high;
        logic upper_byte_enable_n;
        logic lower_byte_enable_n;
        logic write_n;
    } dpsp_ctrl_type;

    // Read data as it leaves the pipeline
    typedef struct packed {
        logic [`DPSP_DATA_W-1:0] data;
        logic                    upper_drive;
        logic                    lower_drive;
    } dpsp_rdata_type;

endpackage

// ===== dpsp_mem.sv
`timescale 1ns/100ps
`include "dpsp_defines.svh"

// Storage array with byte-lane write and registered read
module dpsp_mem #(
    parameter int ADDR_W = `DPSP_ADDR_W,
    parameter int DATA_W = `DPSP_DATA_W,
    parameter int LANE_W = `DPSP_LANE_W
) (
    input  wire logic              i_clk,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic              i_wr_upper,
    input  wire logic              i_wr_lower,
    input  wire logic [DATA_W-1:0] i_wdata,
    output logic      [DATA_W-1:0] o_rdata
);
    logic [DATA_W-1:0] array [0:(1<<ADDR_W)-1];

    // Storage has no reset, like the real cells
    always_ff @(posedge i_clk) begin
        if (i_wr_upper) begin
            array[i_addr][DATA_W-1:LANE_W] <= i_wdata[DATA_W-1:LANE_W];
        end
        if (i_wr_lower) begin
            array[i_addr][LANE_W-1:0] <= i_wdata[LANE_W-1:0];
        end
        o_rdata <= array[i_addr];
    end
endmodule

// ===== dpsp_port.sv
`timescale 1ns/100ps
`include "dpsp_defines.svh"

// Functional notes
// R1: Without load or advance the address holds, read data stays put.
// R2: Access address is pins when load low, counter when load high.
// R3: Load held low captures a new external address every edge.
// R4: Output drive state follows controls sampled two cycles before.
// R5: Counter clear adds no dead cycle; access proceeds same cycle.
// R6: Access coincident with counter clear goes to location zero.
// R7: Advance low at an edge increments the internal address by one.
// R8: A write with advance lands on the incremented address.
// R9: All input registers load only on the rising clock edge.
// R10: Write strobe is internal and self-timed, not edge-shaped.
// R11: Output enable gates data drivers asynchronously.
// R12: Advance high with no load holds the counter value.
// R13: One deselected sample puts the port into power-down.
// R14: Two selected samples needed before outputs drive again.
// R15: Host uses the two chip selects as a bank decode; dpsp_host drives both from one sel input.
// R16: Host ties controls of several parts for wider words.
// R17: Deselect or both byte enables high gives high-impedance output.
// R18: Each lane tri-states per its byte enable; data two cycles later.
// R19: Counter is 15 bits and wraps from top address to zero.
// R20: Counter clear beats address load; access goes to zero.
module dpsp_port
    import dpsp_pkg::*;
#(
    parameter int ADDR_W = `DPSP_ADDR_W,
    parameter int DATA_W = `DPSP_DATA_W,
    parameter int LANE_W = `DPSP_LANE_W
) (
    input  wire logic                  i_clk,
    input  wire logic                  i_nrst,
    input  wire dpsp_pkg::dpsp_ctrl_type i_ctrl,
    input  wire logic [ADDR_W-1:0]     i_addr,
    input  wire logic [DATA_W-1:0]     i_data,
    input  wire logic                  i_output_enable_n,
    output logic      [DATA_W-1:0]     o_data,
    output logic      [DATA_W-1:0]     o_data_oe_n,
    output logic                       o_power_down,
    output logic      [ADDR_W-1:0]     o_internal_addr
);
    import dpsp_pkg::*;

    typedef struct packed {
        dpsp_ctrl_type            ctrl;
        logic [ADDR_W-1:0]        ext_addr;
        logic [DATA_W-1:0]        wdata;
        logic [ADDR_W-1:0]        counter;
        logic                     rd_vld;
        logic                     up_drv1;
        logic                     lo_drv1;
        logic                     up_drv2;
        logic                     lo_drv2;
        dpsp_power_type           power;
        logic [`DPSP_REACT_W-1:0] react_cnt;
    } dpsp_state_type;

    dpsp_state_type    state;
    dpsp_state_type    next_state;
    logic [ADDR_W-1:0] access_addr;
    logic              selected;
    logic              wr_upper;
    logic              wr_lower;
    logic [DATA_W-1:0] mem_rdata;

    function automatic logic is_selected(input dpsp_ctrl_type c);
        return !c.chip_select_active_low && c.chip_select_active_high;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Address selection on the registered controls

    always_comb begin
        selected = is_selected(state.ctrl);
        // R6: coincident access at zero
        // R20: clear beats load
        if (!state.ctrl.counter_clear_n) begin
            access_addr = `DPSP_ADDR_ZERO;
        // R2: pins when load low
        // R3: fresh address each edge
        end else if (!state.ctrl.address_load_n) begin
            access_addr = state.ext_addr;
        end else begin
            access_addr = state.counter;
        end
    end

    // R10: self-timed strobe from registered write, no clock-edge shaping
    assign wr_upper = selected && !state.ctrl.write_n
                      && !state.ctrl.upper_byte_enable_n;
    assign wr_lower = selected && !state.ctrl.write_n
                      && !state.ctrl.lower_byte_enable_n;

    dpsp_mem #(
        .ADDR_W (ADDR_W),
        .DATA_W (DATA_W),
        .LANE_W (LANE_W)
    ) u_mem (
        .i_clk      (i_clk),
        .i_addr     (access_addr),
        .i_wr_upper (wr_upper),
        .i_wr_lower (wr_lower),
        .i_wdata    (state.wdata),
        .o_rdata    (mem_rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        next_state = state;
        // R9: inputs captured each rising edge
        next_state.ctrl     = i_ctrl;
        next_state.ext_addr = i_addr;
        next_state.wdata    = i_data;
        // R5: counter follows the access with no dead cycle
        // R7: advance steps the counter by one, and that same sample accesses the stepped address
        // R8: advance with a write lands on the stepped address
        // R19: wraps naturally at the top
        if (!i_ctrl.counter_clear_n) begin
            next_state.counter = `DPSP_ADDR_ZERO;
        end else if (!i_ctrl.address_load_n) begin
            next_state.counter = i_addr;
        end else if (!i_ctrl.count_advance_n) begin
            next_state.counter = ADDR_W'(state.counter + 1'b1);
        end else begin
            // R1: hold
            // R12: hold
            next_state.counter = state.counter;
        end
        // R4: drive state follows the previous sample
        next_state.rd_vld  = selected && state.ctrl.write_n
                             && state.power == DPSP_ACTIVE;
        next_state.up_drv1 = !state.ctrl.upper_byte_enable_n;
        next_state.lo_drv1 = !state.ctrl.lower_byte_enable_n;
        // R18: lane enables travel with data to cycle two
        next_state.up_drv2 = state.rd_vld && state.up_drv1;
        next_state.lo_drv2 = state.rd_vld && state.lo_drv1;
        // R13: one deselect sample
        // R14: two selected samples to wake
        case (state.power)
            DPSP_ACTIVE: begin
                if (!is_selected(i_ctrl)) begin
                    next_state.power = DPSP_POWER_DOWN;
                end
            end
            DPSP_POWER_DOWN: begin
                if (is_selected(i_ctrl)) begin
                    next_state.power     = DPSP_WAKE;
                    next_state.react_cnt = `DPSP_REACT_W'(1);
                end
            end
            DPSP_WAKE: begin
                if (!is_selected(i_ctrl)) begin
                    next_state.power = DPSP_POWER_DOWN;
                end else if (state.react_cnt + 1'b1 >= `DPSP_REACT_CYC) begin
                    next_state.power = DPSP_ACTIVE;
                end else begin
                    next_state.react_cnt =
                        `DPSP_REACT_W'(state.react_cnt + 1'b1);
                end
            end
            default: begin
                next_state.power = DPSP_POWER_DOWN;
            end
        endcase
    end

    // Counter address is the counter itself, but the memory sees the
    // registered mux, so advance in the same sample uses the new value.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state <= '{ctrl: 8'hFF, ext_addr: '0, wdata: '0,
                       counter: '0, rd_vld: 1'b0, up_drv1: 1'b0,
                       lo_drv1: 1'b0, up_drv2: 1'b0, lo_drv2: 1'b0,
                       power: DPSP_POWER_DOWN, react_cnt: '0};
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_data <= '0;
        end else begin
            o_data <= mem_rdata;
        end
    end

    // R11: asynchronous output enable gate
    // R17: tri-state when deselected or lanes off
    always_comb begin
        o_data_oe_n = '1;
        if (!i_output_enable_n && state.up_drv2) begin
            o_data_oe_n[DATA_W-1:LANE_W] = '0;
        end
        if (!i_output_enable_n && state.lo_drv2) begin
            o_data_oe_n[LANE_W-1:0] = '0;
        end
    end

    assign o_power_down    = state.power != DPSP_ACTIVE;
    assign o_internal_addr = access_addr;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    clear_to_zero_a: assert property ( // R6
        @(posedge i_clk) disable iff (!i_nrst)
        !i_ctrl.counter_clear_n
        |=> access_addr == '0 && state.counter == '0)
        else $error("clear access not at zero");

    advance_step_a: assert property ( // R7
        @(posedge i_clk) disable iff (!i_nrst)
        (i_ctrl.counter_clear_n && i_ctrl.address_load_n
         && !i_ctrl.count_advance_n)
        |=> access_addr == ADDR_W'($past(state.counter) + 1'b1))
        else $error("advance did not step by one");

    hold_addr_a: assert property ( // R1
        @(posedge i_clk) disable iff (!i_nrst)
        (i_ctrl.counter_clear_n && i_ctrl.address_load_n
         && i_ctrl.count_advance_n) |=> $stable(state.counter))
        else $error("counter moved while held");

    load_addr_a: assert property ( // R3
        @(posedge i_clk) disable iff (!i_nrst)
        (i_ctrl.counter_clear_n && !i_ctrl.address_load_n)
        |=> access_addr == $past(i_addr))
        else $error("external address not loaded");

    deselect_down_a: assert property ( // R13
        @(posedge i_clk) disable iff (!i_nrst)
        !is_selected(i_ctrl) |=> o_power_down)
        else $error("deselect did not power down");

    wake_two_a: assert property ( // R14
        @(posedge i_clk) disable iff (!i_nrst)
        o_power_down ##1 !o_power_down |-> selected && $past(selected))
        else $error("woke without two selected samples");

    float_off_a: assert property ( // R17
        @(posedge i_clk) disable iff (!i_nrst)
        !selected |-> ##2 o_data_oe_n == '1)
        else $error("outputs drove after deselect");

    lane_off_a: assert property ( // R18
        @(posedge i_clk) disable iff (!i_nrst)
        state.ctrl.upper_byte_enable_n
        |-> ##2 &o_data_oe_n[DATA_W-1:LANE_W])
        else $error("upper lane drove while disabled");

    oe_gate_a: assert property ( // R11
        @(posedge i_clk) disable iff (!i_nrst)
        i_output_enable_n |-> o_data_oe_n == '1)
        else $error("output enable ignored");
endmodule

// ===== dpsp_host.sv
`timescale 1ns/100ps
`include "dpsp_defines.svh"

// Host master on the port pins; one call drives one cycle
module dpsp_host
    import dpsp_pkg::*;
(
    input  wire logic                        i_clk,
    output dpsp_pkg::dpsp_ctrl_type          o_ctrl,
    output logic      [`DPSP_ADDR_W-1:0]     o_addr,
    output logic      [`DPSP_DATA_W-1:0]     o_data
);
    initial begin
        o_ctrl = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
        o_addr = 15'h0000;
        o_data = 18'h00000;
    end

    task automatic op(input logic ld_n, adv_n, clr_n, wr_n, ub_n, lb_n,
                      input logic sel,
                      input logic [`DPSP_ADDR_W-1:0] a,
                      input logic [`DPSP_DATA_W-1:0] d);
        @(posedge i_clk);
        o_ctrl <= '{ld_n, adv_n, clr_n, !sel, sel, ub_n, lb_n, wr_n};
        o_addr <= a;
        // Released data bus shows the inverse, never a stale copy
        o_data <= wr_n ? ~o_data : d;
        #1;
    endtask
endmodule

// ===== dpsp_port_bench.sv
`timescale 1ns/100ps
`include "dpsp_defines.svh"

module dpsp_port_bench;
    import dpsp_pkg::*;
    logic          i_clk;
    logic          i_nrst;
    logic          oe_n;
    logic          pdn;
    dpsp_ctrl_type ctrl;
    logic [14:0]   addr;
    logic [14:0]   ia;
    logic [17:0]   wdata;
    logic [17:0]   rdata;
    logic [17:0]   oe_bits;
    int            miscompares = 0;
    int            n_checks = 0;
    int            cycles = 0;

    dpsp_port dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_ctrl(ctrl),
        .i_addr(addr), .i_data(wdata), .i_output_enable_n(oe_n),
        .o_data(rdata), .o_data_oe_n(oe_bits), .o_power_down(pdn),
        .o_internal_addr(ia));
    dpsp_host host (.i_clk(i_clk), .o_ctrl(ctrl), .o_addr(addr),
        .o_data(wdata));

    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end
////////////////////////////////////////////////////////////////////////
    task automatic chk_d(input logic [17:0] g, e);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value at %0t: data %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk_a(input logic [14:0] g, e);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value at %0t: addr %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk_b(input logic g, e);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value at %0t: flag %b exp %b", $time, g, e);
        end
    endtask
    task automatic rd(input logic [14:0] a);
        host.op(1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, a, 18'h00000);
    endtask
    task automatic wr(input logic [14:0] a, input logic [17:0] d);
        host.op(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, a, d);
    endtask
    task automatic nop(input int n);
        repeat (n) begin
            host.op(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 15'h0000,
                    18'h00000);
        end
    endtask
////////////////////////////////////////////////////////////////////////
    task automatic t_wake;
        chk_b(pdn, 1'b1);
        chk_d(oe_bits, 18'h3FFFF);
        nop(2);
        chk_b(pdn, 1'b1);
        nop(1);
        chk_b(pdn, 1'b0);
    endtask
    task automatic t_load;
        wr(15'h000A, 18'h2A5C3);
        wr(15'h0014, 18'h15A3C);
        rd(15'h000A);
        rd(15'h0014);
        chk_a(ia, 15'h000A);
        nop(1);
        chk_a(ia, 15'h0014);
        chk_d(oe_bits, 18'h3FFFF);
        nop(1);
        chk_d(rdata, 18'h2A5C3);
        nop(1);
        chk_d(rdata, 18'h15A3C);
        chk_d(oe_bits, 18'h00000);
    endtask
    task automatic t_count;
        wr(15'h0100, 18'h01111);
        host.op(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 15'h0000,
                18'h32222);
        nop(1);
        chk_a(ia, 15'h0101);
        rd(15'h0101);
        nop(3);
        chk_d(rdata, 18'h32222);
        nop(2);
        chk_d(rdata, 18'h32222);
        chk_a(ia, 15'h0101);
        rd(15'h7FFF);
        host.op(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 15'h0000,
                18'h00000);
        nop(1);
        chk_a(ia, 15'h0000);
    endtask
    task automatic t_clear;
        host.op(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 15'h0055,
                18'h2BEEF);
        rd(15'h0000);
        chk_a(ia, 15'h0000);
        nop(3);
        chk_d(rdata, 18'h2BEEF);
    endtask
    task automatic t_lanes;
        host.op(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 15'h000A,
                18'h00000);
        nop(3);
        chk_d(oe_bits, 18'h3FE00);
        @(posedge i_clk) oe_n <= 1'b1;
        #1 chk_d(oe_bits, 18'h3FFFF);
        @(posedge i_clk) oe_n <= 1'b0;
        #1 chk_d(oe_bits, 18'h00000);
        host.op(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 15'h0000,
                18'h00000);
        // Lane drive lags the sample by two edges
        nop(3);
        chk_d(oe_bits, 18'h3FFFF);
        host.op(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 15'h0000,
                18'h00000);
        nop(1);
        chk_b(pdn, 1'b1);
        nop(2);
        chk_d(oe_bits, 18'h3FFFF);
        chk_b(pdn, 1'b0);
    endtask
////////////////////////////////////////////////////////////////////////
    task automatic give_verdict;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Whole run is well under a hundred cycles
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            miscompares++;
            give_verdict();
        end
    end

    initial begin
        i_nrst = 1'b0;
        oe_n = 1'b0;
        repeat (2) @(posedge i_clk);
        i_nrst <= 1'b1;
        #1;
        t_wake();
        t_load();
        t_count();
        t_clear();
        t_lanes();
        give_verdict();
    end
endmodule
